// >>> design/cpuix_consts.svh
// constants of the pipelined core with indexed literal offset addressing
`ifndef CPUIX_CONSTS_SVH
`define CPUIX_CONSTS_SVH
`define CPUIX_PC_W        16
`define CPUIX_IW_W        16
`define CPUIX_DA_W        12
`define CPUIX_NOP_WORD    16'h0000
`define CPUIX_PC_RST      16'h0000
`define CPUIX_W_RST       8'h00
// top nibble classes of the instruction word
`define CPUIX_CLS_BIT     4'h8
`define CPUIX_CLS_LIT     4'h9
`define CPUIX_CLS_JUMP    4'hd
// eight extended two-word commands share this upper byte pattern
`define CPUIX_EXT_MASK    8'hf8
`define CPUIX_EXT_CODE    8'he8
// highest operand that selects indexed literal offset
`define CPUIX_IDX_MAX     8'h5f
// operand at or above this in the shared bank maps to the upper page
`define CPUIX_ACC_SPLIT   8'h80
`define CPUIX_ACC_HI_PAGE 4'hf
`define CPUIX_ACC_LO_PAGE 4'h0
// field positions
`define CPUIX_F_A         8
`define CPUIX_F_D         9
`endif

// >>> design/cpuix_pkg.sv
// types shared by the core and its memory ports
`include "cpuix_consts.svh"
package cpuix_pkg;
  typedef enum logic [3:0] {
    phase_one   = 4'b0001,
    phase_two   = 4'b0010,
    phase_three = 4'b0100,
    phase_four  = 4'b1000
  } cpuix_phase_e;

  typedef enum logic [1:0] {
    mode_bank  = 2'b00,
    mode_share = 2'b01,
    mode_index = 2'b10
  } cpuix_amode_e;

  typedef struct packed {
    logic [`CPUIX_DA_W-1:0] addr;
    logic                   rd;
    logic                   wr;
    logic [7:0]             wdata;
  } cpuix_dm_req_s;

  typedef struct packed {
    logic [3:0]             bank_select;
    logic [`CPUIX_DA_W-1:0] index_pointer_zero;
    logic [`CPUIX_DA_W-1:0] index_pointer_one;
    logic [`CPUIX_DA_W-1:0] index_pointer_two;
  } cpuix_ptr_s;
endpackage

// >>> design/cpuix_core.sv
// four-phase pipelined core with indexed literal offset address generation
`timescale 1ns/1ps
`default_nettype none
`include "cpuix_consts.svh"

module cpuix_core (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      extended_set_enable,
  input  wire cpuix_pkg::cpuix_ptr_s     ptr,
  output logic [`CPUIX_PC_W-1:0]         pm_addr,
  input  wire logic [`CPUIX_IW_W-1:0]    pm_rdata,
  output var cpuix_pkg::cpuix_dm_req_s   dm_req,
  input  wire logic [7:0]                dm_rdata,
  output var cpuix_pkg::cpuix_phase_e    phase,
  output logic [`CPUIX_IW_W-1:0]         instruction_register,
  output logic [7:0]                     wreg
);
  import cpuix_pkg::*;

  // ==========================================================
  // decode helpers
  function automatic logic is_jump(input logic [`CPUIX_IW_W-1:0] w);
    return w[15:12] == `CPUIX_CLS_JUMP;
  endfunction

  function automatic logic is_ext(input logic [`CPUIX_IW_W-1:0] w, input logic en);
    return en && ((w[15:8] & `CPUIX_EXT_MASK) == `CPUIX_EXT_CODE);
  endfunction

  function automatic logic is_file_op(input logic [`CPUIX_IW_W-1:0] w);
    // the all-zero word is the no-operation slot and must not touch data memory or w
    return ((w[15:14] == 2'b00) && (w != `CPUIX_NOP_WORD)) || (w[15:12] == `CPUIX_CLS_BIT);
  endfunction

  function automatic cpuix_amode_e amode(input logic [`CPUIX_IW_W-1:0] w, input logic en);
    if (w[`CPUIX_F_A]) begin
      return mode_bank;
    end else if (en && (w[7:0] <= `CPUIX_IDX_MAX)) begin
      return mode_index;
    end
    return mode_share;
  endfunction

  function automatic logic [`CPUIX_DA_W-1:0] data_addr(input logic [`CPUIX_IW_W-1:0] w,
                                                       input logic en,
                                                       input cpuix_ptr_s p);
    logic [`CPUIX_DA_W-1:0] a;
    a = '0;
    unique case (amode(w, en))
      mode_bank:  a = {p.bank_select, w[7:0]};
      mode_index: a = p.index_pointer_two + {4'h0, w[7:0]};
      default: begin
        if (w[7:0] >= `CPUIX_ACC_SPLIT) begin
          a = {`CPUIX_ACC_HI_PAGE, w[7:0]};
        end else begin
          a = {`CPUIX_ACC_LO_PAGE, w[7:0]};
        end
      end
    endcase
    return a;
  endfunction

  // ==========================================================
  // phase generator
  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= phase_one;
    end else if (ce) begin
      unique case (phase)
        phase_one:   phase <= phase_two;
        phase_two:   phase <= phase_three;
        phase_three: phase <= phase_four;
        phase_four:  phase <= phase_one;
        default:     phase <= phase_one;
      endcase
    end
  end

  // ==========================================================
  // fetch stage
  logic [`CPUIX_IW_W-1:0] fetch_word_reg;
  logic [`CPUIX_IW_W-1:0] second_word_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      pm_addr <= `CPUIX_PC_RST;
    end else if (ce && phase == phase_one) begin
      if (is_jump(instruction_register)) begin
        pm_addr <= {4'h0, instruction_register[11:0]};
      end else begin
        pm_addr <= pm_addr + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fetch_word_reg <= `CPUIX_NOP_WORD;
    end else if (ce && phase == phase_four) begin
      fetch_word_reg <= pm_rdata;
    end
  end

  // ==========================================================
  // instruction register: jump and two-word slots execute as no-operation
  always_ff @(posedge clock) begin
    if (rst) begin
      instruction_register <= `CPUIX_NOP_WORD;
      second_word_reg      <= `CPUIX_NOP_WORD;
    end else if (ce && phase == phase_one) begin
      if (is_jump(instruction_register)) begin
        instruction_register <= `CPUIX_NOP_WORD;
      end else if (is_ext(instruction_register, extended_set_enable)) begin
        instruction_register <= `CPUIX_NOP_WORD;
        second_word_reg      <= fetch_word_reg;
      end else begin
        instruction_register <= fetch_word_reg;
      end
    end
  end

  // ==========================================================
  // execute stage
  logic                   file_op;
  logic [`CPUIX_DA_W-1:0] ex_addr;
  logic [7:0]             operand_reg;
  logic [7:0]             result;
  logic                   to_file;

  assign file_op = is_file_op(instruction_register);
  assign ex_addr = data_addr(instruction_register, extended_set_enable, ptr);
  assign to_file = file_op && (instruction_register[15:12] == `CPUIX_CLS_BIT ||
                               instruction_register[`CPUIX_F_D]);

  always_comb begin
    result = operand_reg;
    if (instruction_register[15:12] == `CPUIX_CLS_BIT) begin
      result = operand_reg | (8'h01 << instruction_register[11:9]);
    end else begin
      unique case (instruction_register[13:12])
        2'b00: result = operand_reg;
        2'b01: result = operand_reg + 8'h01;
        2'b10: result = operand_reg + wreg;
        2'b11: result = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      operand_reg <= 8'h00;
    end else if (ce && phase == phase_two && file_op) begin
      operand_reg <= dm_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wreg <= `CPUIX_W_RST;
    end else if (ce && phase == phase_four) begin
      if (instruction_register[15:12] == `CPUIX_CLS_LIT) begin
        wreg <= instruction_register[7:0];
      end else if (file_op && !to_file) begin
        wreg <= result;
      end
    end
  end

  assign dm_req.addr  = ex_addr;
  assign dm_req.rd    = file_op && phase == phase_two;
  assign dm_req.wr    = to_file && phase == phase_four;
  assign dm_req.wdata = result;

  // ==========================================================
  // checks
  sequence s_rotate;
    phase == phase_two ##1 phase == phase_three ##1 phase == phase_four ##1 phase == phase_one;
  endsequence

  property p_rotate;
    @(posedge clock) disable iff (rst || !ce)
      phase == phase_one |=> s_rotate;
  endproperty
  a_rotate: assert property (p_rotate) else $error("phases do not rotate");

  property p_pc_step;
    @(posedge clock) disable iff (rst)
      (ce && phase == phase_one && !is_jump(instruction_register))
        |=> pm_addr == $past(pm_addr) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not step");

  property p_pc_hold;
    @(posedge clock) disable iff (rst)
      (phase != phase_one) |=> $stable(pm_addr);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved off phase one");

  property p_fetch;
    @(posedge clock) disable iff (rst)
      (ce && phase == phase_four) |=> fetch_word_reg == $past(pm_rdata);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch word missed");

  property p_ir_load;
    @(posedge clock) disable iff (rst)
      (ce && phase == phase_one && !is_jump(instruction_register) &&
       !is_ext(instruction_register, extended_set_enable))
        |=> instruction_register == $past(fetch_word_reg);
  endproperty
  a_ir_load: assert property (p_ir_load) else $error("ir not loaded");

  property p_ir_hold;
    @(posedge clock) disable iff (rst)
      (phase != phase_one) |=> $stable(instruction_register);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("ir changed mid cycle");

  sequence s_jump_taken(logic [`CPUIX_PC_W-1:0] t);
    instruction_register == `CPUIX_NOP_WORD && pm_addr == t;
  endsequence

  property p_jump;
    logic [`CPUIX_PC_W-1:0] t;
    @(posedge clock) disable iff (rst)
      (ce && phase == phase_one && is_jump(instruction_register),
       t = {4'h0, instruction_register[11:0]}) |=> s_jump_taken(t);
  endproperty
  a_jump: assert property (p_jump) else $error("jump not taken cleanly");

  property p_two_word;
    @(posedge clock) disable iff (rst)
      (ce && phase == phase_one && !is_jump(instruction_register) &&
       is_ext(instruction_register, extended_set_enable))
        |=> instruction_register == `CPUIX_NOP_WORD && second_word_reg == $past(fetch_word_reg);
  endproperty
  a_two_word: assert property (p_two_word) else $error("second word not consumed");

  property p_strobes;
    @(posedge clock) disable iff (rst)
      (dm_req.rd |-> phase == phase_two) and (dm_req.wr |-> phase == phase_four);
  endproperty
  a_strobes: assert property (p_strobes) else $error("data strobe in wrong phase");

  property p_index;
    @(posedge clock) disable iff (rst)
      (dm_req.rd && extended_set_enable && !instruction_register[`CPUIX_F_A] &&
       instruction_register[7:0] <= `CPUIX_IDX_MAX)
        |-> dm_req.addr == ptr.index_pointer_two + {4'h0, instruction_register[7:0]};
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_bank;
    @(posedge clock) disable iff (rst)
      (dm_req.rd && instruction_register[`CPUIX_F_A])
        |-> dm_req.addr == {ptr.bank_select, instruction_register[7:0]};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_share;
    @(posedge clock) disable iff (rst)
      (dm_req.rd && !extended_set_enable && !instruction_register[`CPUIX_F_A])
        |-> dm_req.addr == {((instruction_register[7:0] >= `CPUIX_ACC_SPLIT) ?
                             `CPUIX_ACC_HI_PAGE : `CPUIX_ACC_LO_PAGE),
                            instruction_register[7:0]};
  endproperty
  a_share: assert property (p_share) else $error("shared bank address wrong");
endmodule
`default_nettype wire

// >>> verification/cpuix_mem_model.sv
// program and data memory model facing the core
`timescale 1ns/1ps
`default_nettype none
module cpuix_mem_model (
  input  wire logic                   clock,
  input  wire logic [15:0]            pm_addr,
  output logic [15:0]                 pm_rdata,
  input  wire cpuix_pkg::cpuix_dm_req_s dm_req,
  output logic [7:0]                  dm_rdata
);
  import cpuix_pkg::*;
  // ====================================
  // memory arrays
  logic [15:0] prog [256];
  logic [7:0]  dmem [4096];
  logic [7:0]  last_q;
  assign pm_rdata = prog[pm_addr[7:0]];
  // a deselected read bus shows the inverse of the last value, never stale data
  always_comb dm_rdata = dm_req.rd ? dmem[dm_req.addr] : ~last_q;
  always @(posedge clock) begin
    if (dm_req.rd) last_q <= dmem[dm_req.addr];
    if (dm_req.wr) dmem[dm_req.addr] <= dm_req.wdata;
  end
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 4096; i++) dmem[i] = 8'(i * 7 + 3);
  end
endmodule
`default_nettype wire

// >>> verification/cpu_pipeline_indexed_addressing_tb.sv
// self-checking bench of the four-phase core against a reference model
`timescale 1ns/1ps
`default_nettype none
module cpu_pipeline_indexed_addressing_tb;
  import cpuix_pkg::*;
  logic          clock = 0, rst = 1, ce = 1, ext = 0, fo, wrx, jmp;
  cpuix_ptr_s    ptr = '0;
  logic [15:0]   pm_addr, pm_rdata, ir, e_pc = 16'h0, e_ir = 16'h0, tmp = 16'h0;
  cpuix_dm_req_s dm_req;
  cpuix_phase_e  phase;
  logic [7:0]    dm_rdata, wreg, w = 0, rdv = 0, res;
  logic [7:0]    mem_m [4096];
  logic [7:0]    fb [6] = '{8'h00, 8'h5f, 8'h60, 8'h7f, 8'h80, 8'hff};
  int            fail_count = 0, n_checks = 0, seed = 32'hc798, q = 0;

  cpuix_core uut (.clock(clock), .rst(rst), .ce(ce), .extended_set_enable(ext), .ptr(ptr),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_rdata(dm_rdata),
    .phase(phase), .instruction_register(ir), .wreg(wreg));
  cpuix_mem_model mem (.clock(clock), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_req(dm_req), .dm_rdata(dm_rdata));

  initial forever #5 clock = ~clock;

  // ====================================
  // checking helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [11:0] ea(input logic [15:0] i);
    if (i[8]) return {ptr.bank_select, i[7:0]};
    if (ext && i[7:0] <= 8'h5f) return ptr.index_pointer_two + 12'(i[7:0]);
    return {i[7] ? 4'hf : 4'h0, i[7:0]};
  endfunction

  // random words with boundary file operands and some extended two-word encodings
  function automatic logic [15:0] gen();
    logic [15:0] r, g;
    logic [7:0]  f;
    int          k;
    r = 16'($random(seed));
    k = {$random(seed)} % 11;
    f = r[0] ? fb[{$random(seed)} % 6] : 8'($random(seed));
    if (k < 6) g = {2'b00, r[13:12], 2'b00, r[9:8], f};
    else if (k < 8) g = {4'h8, r[11:8], f};
    else if (k < 9) g = {8'h90, f};
    else if (k < 10) g = {8'hd0, r[7:0]};
    else g = {5'h1d, r[10:8], f};
    return (g == 16'h0) ? 16'h9001 : g;
  endfunction

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_of_test;
  end

  initial begin
    for (int i = 0; i < 4096; i++) mem_m[i] = 8'(i * 7 + 3);
    for (int i = 0; i < 256; i++) mem.prog[i] = gen();
    for (int cyc = 0; cyc < 6000; cyc++) begin
      @(negedge clock);
      fo = (e_ir[15:14] == 2'b00 && e_ir != 16'h0) || e_ir[15:12] == 4'h8;
      wrx = fo && (e_ir[15] || e_ir[9]);
      jmp = e_ir[15:12] == 4'hd;
      chk(phase, 16'(1 << q));
      chk(dm_req.rd, 16'(q == 1 && fo));
      chk(dm_req.wr, 16'(q == 3 && wrx));
      if (q == 0) begin
        chk(ir, e_ir);
        chk(wreg, w);
      end
      if (q == 1 && fo) begin
        chk(dm_req.addr, ea(e_ir));
        rdv = mem_m[ea(e_ir)];
      end
      res = e_ir[15] ? rdv | 8'(1 << e_ir[11:9]) : e_ir[13:12] == 2'd0 ? rdv :
            e_ir[13:12] == 2'd1 ? rdv + 8'h1 : e_ir[13:12] == 2'd2 ? rdv + w : 8'h0;
      if (q == 3) begin
        chk(pm_addr, e_pc);
        if (wrx) begin
          chk(dm_req.wdata, res);
          mem_m[ea(e_ir)] = res;
        end
      end
      // inputs change at the falling edge; pointers only ahead of an operand read
      rst = cyc < 16 || (cyc >= 3000 && cyc < 3003);
      ce = rst ? 1'b1 : ({$random(seed)} % 5 != 0);
      if (q == 0) begin
        ext = 1'($random(seed));
        ptr = 40'({$random(seed), $random(seed)});
      end
      if (rst) begin
        q = 0;
        e_pc = 16'h0;
        e_ir = 16'h0;
        tmp = 16'h0;
        w = 8'h0;
      end else if (ce) begin
        // pc and ir move on the edge that ends phase one; the word came in at the end of phase four
        if (q == 0) begin
          e_pc = jmp ? {4'h0, e_ir[11:0]} : e_pc + 16'h1;
          e_ir = (jmp || (ext && e_ir[15:11] == 5'h1d)) ? 16'h0 : tmp;
        end
        if (q == 3) begin
          if (fo && !wrx) w = res;
          if (e_ir[15:12] == 4'h9) w = e_ir[7:0];
          tmp = mem.prog[e_pc[7:0]];
        end
        q = (q + 1) % 4;
      end
    end
    end_of_test;
  end
endmodule
`default_nettype wire
